// file: hdl/rcch_pkg.sv
package rcch_pkg;

  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int FR_DELAY_MS = 100;
  localparam int CT_UNIT_MS = 100;

  // addressing marker selecting 64-bit mode
  localparam logic [15:0] ADDR16_USE64 = 16'hFFFE;

  // factory defaults
  localparam logic [31:0] DEF_DEST_LOW = 32'h0000_0000;
  localparam logic [2:0] DEF_RATE = 3'h3;
  localparam logic [2:0] RATE_MAX = 3'h7;
  localparam logic [15:0] DEF_GUARD_MS = 16'h03E8;
  localparam logic [7:0] DEF_ESC_CHAR = 8'h2B;
  localparam logic [15:0] DEF_CMD_TIMEOUT = 16'h0064;

  // characters
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] CHR_COMMA = 8'h2C;
  localparam logic [15:0] CHR_PREFIX = 16'h4154;

  // two-letter command codes
  localparam logic [15:0] CODE_DEST_LOW = 16'h444C;
  localparam logic [15:0] CODE_RATE = 16'h4244;
  localparam logic [15:0] CODE_SAVE = 16'h5752;
  localparam logic [15:0] CODE_RESTORE = 16'h5245;
  localparam logic [15:0] CODE_SWRESET = 16'h4652;
  localparam logic [15:0] CODE_APPLY = 16'h4143;
  localparam logic [15:0] CODE_EXIT = 16'h434E;
  localparam logic [15:0] CODE_GUARD = 16'h4754;
  localparam logic [15:0] CODE_ESC = 16'h4343;
  localparam logic [15:0] CODE_TIMEOUT = 16'h4354;

  // remote status codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_PARAM = 8'h03;

  // register byte offsets and fields
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_RATE = 4'h4;
  localparam logic [3:0] REG_DEST = 4'h8;
  localparam logic [3:0] REG_CTRL = 4'hC;
  localparam int STAT_CMD_MODE = 0;
  localparam int STAT_PENDING = 1;
  localparam int STAT_USE16 = 2;
  localparam int STAT_RST_ARMED = 3;
  localparam int CTRL_APPLY = 0;
  localparam int CTRL_RESTORE = 1;

  typedef enum logic [3:0] {
    RCCH_CMD_NONE, RCCH_CMD_DEST, RCCH_CMD_RATE, RCCH_CMD_SAVE,
    RCCH_CMD_RESTORE, RCCH_CMD_SWRST, RCCH_CMD_APPLY, RCCH_CMD_EXIT,
    RCCH_CMD_GUARD, RCCH_CMD_ESC, RCCH_CMD_TIMEOUT
  } rcch_cmd_t;

  typedef enum logic [1:0] {RCCH_OUT_OK, RCCH_OUT_ERR, RCCH_OUT_VAL}
    rcch_out_t;

  typedef struct packed {
    logic [31:0] dest_low;
    logic [2:0] rate;
    logic [15:0] guard_ms;
    logic [7:0] esc_char;
    logic [15:0] cmd_timeout;
  } rcch_params_t;

  localparam rcch_params_t DEF_PARAMS = '{DEF_DEST_LOW, DEF_RATE,
    DEF_GUARD_MS, DEF_ESC_CHAR, DEF_CMD_TIMEOUT};

  typedef struct packed {
    logic valid;
    logic [7:0] frame_id;
    logic [63:0] addr64;
    logic [15:0] addr16;
    logic apply;
    logic [15:0] cmd;
    logic has_param;
    logic [31:0] param;
  } rcch_rem_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] frame_id;
    logic use16;
    logic [63:0] addr64;
    logic [15:0] addr16;
    logic [15:0] cmd;
    logic [7:0] status;
    logic has_value;
    logic [31:0] value;
  } rcch_rem_rsp_t;

  typedef struct packed {
    logic valid;
    logic unreachable;
    logic [7:0] frame_id;
    logic [15:0] cmd;
    logic [7:0] status;
    logic has_value;
    logic [31:0] value;
  } rcch_rf_rsp_t;

endpackage

// file: hdl/rcch_top.sv
`timescale 1ns/1ps
module rcch_top #(
  parameter int MS_CYCLES = rcch_pkg::CYC_PER_MS,
  parameter int LINE_DEPTH = 32
) (
  input wire logic clk_i, // 40 MHz clock
  input wire logic rst_i, // sync reset, active high
  input wire logic rx_valid_i, // uart byte strobe
  input wire logic [7:0] rx_data_i, // uart byte
  output logic tx_valid_o, // answer byte valid
  output logic [7:0] tx_data_o, // answer byte
  input wire logic tx_ready_i, // uart takes byte
  input wire rcch_pkg::rcch_rem_req_t rem_req_i, // remote request
  output logic rem_ready_o, // remote request taken
  output rcch_pkg::rcch_rem_rsp_t rem_rsp_o, // response to originator
  input wire rcch_pkg::rcch_rf_rsp_t rf_rsp_i, // response off the air
  output rcch_pkg::rcch_rf_rsp_t host_rsp_o, // response frame to host
  output logic [2:0] serial_rate_o, // live rate select
  output logic [31:0] dest_low_o, // live destination low
  output logic cmd_mode_o, // in command mode
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [3:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o // wishbone ack
);

  typedef enum {
    S_IDLE, S_PREFIX, S_CMD, S_ARG, S_EXEC, S_TX, S_NEXT
  } rcch_state_t;

  localparam int PW = $clog2(LINE_DEPTH + 1);

  typedef struct packed {
    rcch_state_t st;
    logic cmd_mode;
    logic [1:0] plus_cnt;
    logic [15:0] quiet_ms;
    logic [15:0] seq_ms;
    logic [23:0] idle_ms;
    logic [15:0] tick_cnt;
    logic [7:0] rst_ms;
    logic rst_armed;
    logic use16;
    rcch_pkg::rcch_params_t act;
    rcch_pkg::rcch_params_t pend;
    rcch_pkg::rcch_params_t saved;
    logic [LINE_DEPTH-1:0][7:0] line;
    logic [PW-1:0] len;
    logic [PW-1:0] pos;
    logic [15:0] code;
    logic [31:0] val;
    logic has_val;
    logic bad;
    rcch_pkg::rcch_out_t out_kind;
    logic [31:0] out_val;
    logic [3:0] out_digits;
    logic [3:0] out_idx;
    logic [7:0] tx_byte;
    logic wb_ack;
    logic [31:0] wb_dat;
    rcch_pkg::rcch_rem_rsp_t rsp;
    rcch_pkg::rcch_rf_rsp_t host_rsp;
  } rcch_q_t;

  rcch_q_t q;
  rcch_q_t d;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // two-letter code to command id
  function automatic rcch_pkg::rcch_cmd_t cmd_of(input logic [15:0] c);
    unique case (c)
      rcch_pkg::CODE_DEST_LOW: cmd_of = rcch_pkg::RCCH_CMD_DEST;
      rcch_pkg::CODE_RATE: cmd_of = rcch_pkg::RCCH_CMD_RATE;
      rcch_pkg::CODE_SAVE: cmd_of = rcch_pkg::RCCH_CMD_SAVE;
      rcch_pkg::CODE_RESTORE: cmd_of = rcch_pkg::RCCH_CMD_RESTORE;
      rcch_pkg::CODE_SWRESET: cmd_of = rcch_pkg::RCCH_CMD_SWRST;
      rcch_pkg::CODE_APPLY: cmd_of = rcch_pkg::RCCH_CMD_APPLY;
      rcch_pkg::CODE_EXIT: cmd_of = rcch_pkg::RCCH_CMD_EXIT;
      rcch_pkg::CODE_GUARD: cmd_of = rcch_pkg::RCCH_CMD_GUARD;
      rcch_pkg::CODE_ESC: cmd_of = rcch_pkg::RCCH_CMD_ESC;
      rcch_pkg::CODE_TIMEOUT: cmd_of = rcch_pkg::RCCH_CMD_TIMEOUT;
      default: cmd_of = rcch_pkg::RCCH_CMD_NONE;
    endcase
  endfunction

  // command names a stored parameter
  function automatic logic is_param(input rcch_pkg::rcch_cmd_t c);
    is_param = (c == rcch_pkg::RCCH_CMD_DEST) ||
      (c == rcch_pkg::RCCH_CMD_RATE) || (c == rcch_pkg::RCCH_CMD_GUARD) ||
      (c == rcch_pkg::RCCH_CMD_ESC) || (c == rcch_pkg::RCCH_CMD_TIMEOUT);
  endfunction

  // current value of a parameter
  function automatic logic [31:0] get_param(input rcch_pkg::rcch_params_t p,
      input rcch_pkg::rcch_cmd_t c);
    get_param = 32'h0000_0000;
    if (c == rcch_pkg::RCCH_CMD_DEST) get_param = p.dest_low;
    if (c == rcch_pkg::RCCH_CMD_RATE) get_param = {29'h0, p.rate};
    if (c == rcch_pkg::RCCH_CMD_GUARD) get_param = {16'h0, p.guard_ms};
    if (c == rcch_pkg::RCCH_CMD_ESC) get_param = {24'h0, p.esc_char};
    if (c == rcch_pkg::RCCH_CMD_TIMEOUT) get_param = {16'h0, p.cmd_timeout};
  endfunction

  // store a parameter value
  function automatic rcch_pkg::rcch_params_t set_param(
      input rcch_pkg::rcch_params_t p, input rcch_pkg::rcch_cmd_t c,
      input logic [31:0] v);
    set_param = p;
    if (c == rcch_pkg::RCCH_CMD_DEST) set_param.dest_low = v;
    if (c == rcch_pkg::RCCH_CMD_RATE) set_param.rate = v[2:0];
    if (c == rcch_pkg::RCCH_CMD_GUARD) set_param.guard_ms = v[15:0];
    if (c == rcch_pkg::RCCH_CMD_ESC) set_param.esc_char = v[7:0];
    if (c == rcch_pkg::RCCH_CMD_TIMEOUT) set_param.cmd_timeout = v[15:0];
  endfunction

  // value fits the parameter
  function automatic logic in_range(input rcch_pkg::rcch_cmd_t c,
      input logic [31:0] v);
    in_range = 1'b1;
    if (c == rcch_pkg::RCCH_CMD_RATE) in_range = (v <= 32'(rcch_pkg::RATE_MAX));
    if (c == rcch_pkg::RCCH_CMD_GUARD || c == rcch_pkg::RCCH_CMD_TIMEOUT)
      in_range = (v[31:16] == 16'h0000);
    if (c == rcch_pkg::RCCH_CMD_ESC) in_range = (v[31:8] == 24'h00_0000);
  endfunction

  // ascii hex digit to nibble, bit 4 flags a valid digit
  function automatic logic [4:0] hex_of(input logic [7:0] ch);
    hex_of = 5'h00;
    if (ch >= 8'h30 && ch <= 8'h39) hex_of = {1'b1, 4'(ch - 8'h30)};
    if (ch >= 8'h41 && ch <= 8'h46) hex_of = {1'b1, 4'(ch - 8'h37)};
    if (ch >= 8'h61 && ch <= 8'h66) hex_of = {1'b1, 4'(ch - 8'h57)};
  endfunction

  // significant hex digits, at least one
  function automatic logic [3:0] digits_of(input logic [31:0] v);
    digits_of = 4'h1;
    for (int i = 1; i < 8; i++)
      if (v[4*i +: 4] != 4'h0) digits_of = 4'(i + 1);
  endfunction

  // length of an answer in bytes
  function automatic logic [3:0] out_len(input rcch_pkg::rcch_out_t k,
      input logic [3:0] nd);
    unique case (k)
      rcch_pkg::RCCH_OUT_OK: out_len = 4'h3;
      rcch_pkg::RCCH_OUT_ERR: out_len = 4'h6;
      rcch_pkg::RCCH_OUT_VAL: out_len = nd + 4'h1;
    endcase
  endfunction

  // byte of an answer at a position
  function automatic logic [7:0] out_char(input rcch_pkg::rcch_out_t k,
      input logic [3:0] idx, input logic [31:0] v, input logic [3:0] nd);
    logic [2:0] sel;
    logic [3:0] nib;
    sel = 3'(nd - 4'h1 - idx);
    nib = v[{sel, 2'b00} +: 4];
    out_char = rcch_pkg::CHR_CR;
    unique case (k)
      rcch_pkg::RCCH_OUT_OK:
        if (idx == 4'h0) out_char = 8'h4F;
        else if (idx == 4'h1) out_char = 8'h4B;
      rcch_pkg::RCCH_OUT_ERR:
        if (idx == 4'h0) out_char = 8'h45;
        else if (idx == 4'h3) out_char = 8'h4F;
        else if (idx < 4'h5) out_char = 8'h52;
      rcch_pkg::RCCH_OUT_VAL:
        if (idx < nd)
          out_char = (nib < 4'hA) ? {4'h3, nib} : 8'(8'h37 + nib);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    rcch_pkg::rcch_cmd_t id;
    logic [4:0] hx;
    logic tick;
    logic [7:0] ch;
    logic [23:0] limit;
    id = rcch_pkg::RCCH_CMD_NONE;
    hx = 5'h00;
    tick = 1'b0;
    ch = q.line[q.pos[PW-2:0]];
    limit = 24'(q.act.cmd_timeout * 24'(rcch_pkg::CT_UNIT_MS));
    d = q;
    d.wb_ack = 1'b0;
    d.rsp.valid = 1'b0;
    d.host_rsp.valid = 1'b0;

    // millisecond tick and silence timers
    if (q.tick_cnt == 16'(MS_CYCLES - 1))
    begin
      d.tick_cnt = 16'h0000;
      tick = 1'b1;
    end
    else
      d.tick_cnt = q.tick_cnt + 16'h0001;
    if (tick && q.quiet_ms != 16'hFFFF) d.quiet_ms = q.quiet_ms + 16'h0001;
    if (tick && q.seq_ms != 16'hFFFF) d.seq_ms = q.seq_ms + 16'h0001;
    if (tick && q.cmd_mode && q.idle_ms != 24'hFF_FFFF)
      d.idle_ms = q.idle_ms + 24'h00_0001;
    if (rx_valid_i) d.quiet_ms = 16'h0000;

    // escape detection in data mode
    if (!q.cmd_mode && q.st == S_IDLE)
    begin
      if (rx_valid_i)
      begin
        if (rx_data_i != q.act.esc_char || q.plus_cnt == 2'd3)
          d.plus_cnt = 2'd0;
        else if (q.plus_cnt == 2'd0)
        begin
          if (q.quiet_ms >= q.act.guard_ms)
          begin
            d.plus_cnt = 2'd1;
            d.seq_ms = 16'h0000;
          end
        end
        else if (q.seq_ms < q.act.guard_ms)
          d.plus_cnt = q.plus_cnt + 2'd1;
        else
          d.plus_cnt = 2'd0;
      end
      else if (q.plus_cnt != 2'd3 && q.plus_cnt != 2'd0 &&
               q.seq_ms >= q.act.guard_ms)
        d.plus_cnt = 2'd0;
      else if (q.plus_cnt == 2'd3 && q.quiet_ms >= q.act.guard_ms)
      begin
        d.plus_cnt = 2'd0;
        d.cmd_mode = 1'b1;
        d.idle_ms = 24'h00_0000;
        d.len = '0;
        d.pos = '0;
        d.out_kind = rcch_pkg::RCCH_OUT_OK;
        d.out_idx = 4'h0;
        d.st = S_TX;
      end
    end

    // command timeout back to data mode
    if (q.cmd_mode && q.st == S_IDLE && q.idle_ms >= limit)
      d.cmd_mode = 1'b0;

    unique case (q.st)
      // collect a line, parse only after the carriage return
      S_IDLE:
        if (q.cmd_mode && rx_valid_i)
        begin
          if (rx_data_i == rcch_pkg::CHR_CR)
          begin
            if (q.len != '0) d.st = S_PREFIX;
          end
          else if (q.len != PW'(LINE_DEPTH))
          begin
            d.line[q.len[PW-2:0]] = rx_data_i;
            d.len = q.len + PW'(1);
          end
        end
      S_PREFIX:
      begin
        d.pos = PW'(2);
        d.out_idx = 4'h0;
        if (q.len < PW'(2) || {q.line[0], q.line[1]} != rcch_pkg::CHR_PREFIX)
        begin
          d.pos = q.len;
          d.out_kind = rcch_pkg::RCCH_OUT_ERR;
          d.st = S_TX;
        end
        else if (q.len == PW'(2))
        begin
          d.out_kind = rcch_pkg::RCCH_OUT_OK;
          d.idle_ms = 24'h00_0000;
          d.st = S_TX;
        end
        else
          d.st = S_CMD;
      end
      // two letters of the command name
      S_CMD:
      begin
        d.val = 32'h0000_0000;
        d.has_val = 1'b0;
        d.bad = (q.pos + PW'(1)) >= q.len;
        d.code = {ch, q.line[q.pos[PW-2:0] + 1'b1]};
        d.pos = d.bad ? q.len : q.pos + PW'(2);
        d.st = S_ARG;
      end
      // hex argument up to comma or end of line
      S_ARG:
        if (q.pos == q.len || ch == rcch_pkg::CHR_COMMA)
          d.st = S_EXEC;
        else
        begin
          hx = hex_of(ch);
          d.bad = q.bad | ~hx[4] | (q.val[31:28] != 4'h0);
          d.val = {q.val[27:0], hx[3:0]};
          d.has_val = 1'b1;
          d.pos = q.pos + PW'(1);
        end
      // carry out one command from the line
      S_EXEC:
      begin
        id = cmd_of(q.code);
        d.out_idx = 4'h0;
        d.out_kind = rcch_pkg::RCCH_OUT_OK;
        d.st = S_TX;
        if (q.bad || id == rcch_pkg::RCCH_CMD_NONE ||
            (q.has_val && !is_param(id)) ||
            (q.has_val && !in_range(id, q.val)))
          d.out_kind = rcch_pkg::RCCH_OUT_ERR;
        else
        begin
          d.idle_ms = 24'h00_0000;
          if (is_param(id) && !q.has_val)
          begin
            d.out_kind = rcch_pkg::RCCH_OUT_VAL;
            d.out_val = get_param(q.act, id);
            d.out_digits = digits_of(d.out_val);
          end
          else if (is_param(id))
          begin
            d.act = set_param(q.act, id, q.val);
            d.pend = set_param(q.pend, id, q.val);
          end
          else if (id == rcch_pkg::RCCH_CMD_SAVE)
            d.saved = q.pend;
          else if (id == rcch_pkg::RCCH_CMD_RESTORE)
          begin
            d.act = rcch_pkg::DEF_PARAMS;
            d.pend = rcch_pkg::DEF_PARAMS;
          end
          else if (id == rcch_pkg::RCCH_CMD_APPLY)
            d.act = q.pend;
          else if (id == rcch_pkg::RCCH_CMD_SWRST)
          begin
            d.rst_armed = 1'b1;
            d.rst_ms = 8'h00;
          end
          else
            d.cmd_mode = 1'b0;
        end
      end
      // send the answer bytes
      S_TX:
        if (tx_ready_i)
        begin
          if (q.out_idx == out_len(q.out_kind, q.out_digits) - 4'h1)
            d.st = S_NEXT;
          else
            d.out_idx = q.out_idx + 4'h1;
        end
      S_NEXT:
        if (q.pos < q.len)
        begin
          d.pos = q.pos + PW'(1);
          d.st = S_CMD;
        end
        else
        begin
          d.len = '0;
          d.pos = '0;
          d.st = S_IDLE;
        end
    endcase

    // remote request, changes held pending until applied
    if (q.st == S_IDLE && rem_req_i.valid)
    begin
      id = cmd_of(rem_req_i.cmd);
      d.use16 = rem_req_i.addr16 != rcch_pkg::ADDR16_USE64;
      d.rsp.valid = rem_req_i.frame_id != 8'h00;
      d.rsp.frame_id = rem_req_i.frame_id;
      d.rsp.use16 = d.use16;
      d.rsp.addr64 = d.use16 ? 64'h0 : rem_req_i.addr64;
      d.rsp.addr16 = rem_req_i.addr16;
      d.rsp.cmd = rem_req_i.cmd;
      d.rsp.status = rcch_pkg::ST_OK;
      d.rsp.has_value = 1'b0;
      d.rsp.value = 32'h0000_0000;
      if (id == rcch_pkg::RCCH_CMD_NONE ||
          (rem_req_i.has_param && !is_param(id)))
        d.rsp.status = rcch_pkg::ST_BAD_CMD;
      else if (rem_req_i.has_param && !in_range(id, rem_req_i.param))
        d.rsp.status = rcch_pkg::ST_BAD_PARAM;
      else
      begin
        if (is_param(id) && !rem_req_i.has_param)
        begin
          d.rsp.has_value = 1'b1;
          d.rsp.value = get_param(q.pend, id);
        end
        else if (is_param(id))
          d.pend = set_param(q.pend, id, rem_req_i.param);
        else if (id == rcch_pkg::RCCH_CMD_SAVE)
          d.saved = q.pend;
        else if (id == rcch_pkg::RCCH_CMD_RESTORE)
          d.pend = rcch_pkg::DEF_PARAMS;
        else if (id == rcch_pkg::RCCH_CMD_SWRST)
        begin
          d.rst_armed = 1'b1;
          d.rst_ms = 8'h00;
        end
        if (id == rcch_pkg::RCCH_CMD_APPLY || rem_req_i.apply)
          d.act = d.pend;
      end
    end

    // delayed soft reset reloads the retained set
    if (q.rst_armed && tick)
      d.rst_ms = q.rst_ms + 8'h01;
    if (q.rst_armed && q.rst_ms == 8'(rcch_pkg::FR_DELAY_MS))
    begin
      d.act = q.saved;
      d.pend = q.saved;
      d.rst_armed = 1'b0;
      d.cmd_mode = 1'b0;
      d.plus_cnt = 2'd0;
      d.len = '0;
      d.pos = '0;
      d.st = S_IDLE;
    end

    // forward responses off the air toward the host
    if (rf_rsp_i.valid && !rf_rsp_i.unreachable &&
        rf_rsp_i.frame_id != 8'h00)
    begin
      d.host_rsp = rf_rsp_i;
    end

    // wishbone slave, one wait state
    if (wb_cyc_i && wb_stb_i && !q.wb_ack)
    begin
      d.wb_ack = 1'b1;
      d.wb_dat = 32'h0000_0000;
      if (wb_we_i && wb_adr_i == rcch_pkg::REG_DEST)
      begin
        for (int b = 0; b < 4; b++)
          if (wb_sel_i[b])
          begin
            d.act.dest_low[8*b +: 8] = wb_dat_i[8*b +: 8];
            d.pend.dest_low[8*b +: 8] = wb_dat_i[8*b +: 8];
          end
      end
      else if (wb_we_i && wb_adr_i == rcch_pkg::REG_CTRL && wb_sel_i[0])
      begin
        if (wb_dat_i[rcch_pkg::CTRL_RESTORE])
        begin
          d.pend = rcch_pkg::DEF_PARAMS;
          d.act = rcch_pkg::DEF_PARAMS;
        end
        else if (wb_dat_i[rcch_pkg::CTRL_APPLY])
          d.act = d.pend;
      end
      else if (!wb_we_i)
      begin
        if (wb_adr_i == rcch_pkg::REG_STATUS)
        begin
          d.wb_dat[rcch_pkg::STAT_CMD_MODE] = q.cmd_mode;
          d.wb_dat[rcch_pkg::STAT_PENDING] = q.pend != q.act;
          d.wb_dat[rcch_pkg::STAT_USE16] = q.use16;
          d.wb_dat[rcch_pkg::STAT_RST_ARMED] = q.rst_armed;
        end
        if (wb_adr_i == rcch_pkg::REG_RATE) d.wb_dat = {29'h0, q.act.rate};
        if (wb_adr_i == rcch_pkg::REG_DEST) d.wb_dat = q.act.dest_low;
      end
    end

    d.tx_byte = out_char(d.out_kind, d.out_idx, d.out_val, d.out_digits);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.st <= S_IDLE;
      q.quiet_ms <= 16'hFFFF;
      q.act <= rcch_pkg::DEF_PARAMS;
      q.pend <= rcch_pkg::DEF_PARAMS;
      q.saved <= rcch_pkg::DEF_PARAMS;
      q.out_kind <= rcch_pkg::RCCH_OUT_OK;
    end
    else
      q <= d;
  end

  // outputs
  assign tx_valid_o = q.st == S_TX;
  assign tx_data_o = q.tx_byte;
  assign rem_ready_o = q.st == S_IDLE;
  assign rem_rsp_o = q.rsp;
  assign host_rsp_o = q.host_rsp;
  assign serial_rate_o = q.act.rate;
  assign dest_low_o = q.act.dest_low;
  assign cmd_mode_o = q.cmd_mode;
  assign wb_dat_o = q.wb_dat;
  assign wb_ack_o = q.wb_ack;

endmodule

// file: dv/rcch_checker.sv
`timescale 1ns/1ps
module rcch_checker (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_ack_o, // ack
  input wire logic [2:0] serial_rate_o, // live rate
  input wire logic rem_ready_o, // request taken
  input wire rcch_pkg::rcch_rem_req_t rem_req_i, // request
  input wire rcch_pkg::rcch_rem_rsp_t rem_rsp_o, // response
  input wire rcch_pkg::rcch_rf_rsp_t rf_rsp_i, // air response
  input wire rcch_pkg::rcch_rf_rsp_t host_rsp_o // host frame
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request taken, held change, forwardable air response
  wire take = rem_req_i.valid && rem_ready_o;
  wire idz = rem_req_i.frame_id == 8'h00;
  wire hold = !rem_req_i.apply && rem_req_i.cmd != rcch_pkg::CODE_APPLY;
  wire fwd = rf_rsp_i.frame_id != 8'h00 && !rf_rsp_i.unreachable;
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack missing");
  a_rate_default: assert property (disable iff (1'b0)
    rst_i |=> serial_rate_o == 3'h3) else $error("rate not 3");
  a_rsp_given: assert property (
    take && !idz |=> rem_rsp_o.valid) else $error("no response");
  a_rsp_none: assert property (
    take && idz |=> !rem_rsp_o.valid) else $error("stray response");
  a_addr_mode: assert property (take && !idz |=>
    rem_rsp_o.use16 == ($past(rem_req_i.addr16) != 16'hFFFE))
    else $error("bad address mode");
  a_change_held: assert property (take && hold && !wb_cyc_i
    |=> $stable(serial_rate_o)) else $error("rate changed early");
  a_host_fwd: assert property (rf_rsp_i.valid && fwd
    |=> host_rsp_o.valid) else $error("frame not sent");
  a_host_drop: assert property (rf_rsp_i.valid && !fwd
    |=> !host_rsp_o.valid) else $error("frame sent");
  cover property (take && !hold);
  cover property (rem_rsp_o.valid && rem_rsp_o.has_value);
  cover property (host_rsp_o.valid);
endmodule
bind rcch_top rcch_checker u_chk (.*);

// file: dv/rcch_host.sv
`timescale 1ns/1ps
module rcch_host (
  input wire logic clk_i, // clock
  input wire logic tx_valid_i, // device byte valid
  input wire logic [7:0] tx_data_i, // device byte
  output logic tx_ready_o, // byte taken
  output logic rx_valid_o, // byte to device
  output logic [7:0] rx_data_o // byte value
);
  logic [95:0] got = '0;
  int n_rx = 0;
  initial {tx_ready_o, rx_valid_o, rx_data_o} = '0;
  // slow sink, takes a byte every other edge
  always @(posedge clk_i)
  begin
    tx_ready_o <= ~tx_ready_o;
    if (tx_valid_i && tx_ready_o)
    begin
      got <= {got[87:0], tx_data_i};
      n_rx <= n_rx + 1;
    end
  end
  // whole line, then idle data inverted
  task automatic send(input string s);
    foreach (s[i])
    begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= s[i];
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
  endtask
endmodule

// file: dv/rcch_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module testbench;
  logic clk_i = 0, rst_i = 1, rx_valid_i, tx_valid_o, tx_ready_i;
  logic [7:0] rx_data_i, tx_data_o;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, rem_ready_o;
  logic [3:0] wb_adr_i = '0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = '0, wb_dat_o, dest_low_o, q;
  logic [2:0] serial_rate_o;
  logic cmd_mode_o;
  rcch_pkg::rcch_rem_req_t rem_req_i = '0;
  rcch_pkg::rcch_rem_rsp_t rem_rsp_o;
  rcch_pkg::rcch_rf_rsp_t rf_rsp_i = '0, host_rsp_o;
  int n_fail = 0, checked = 0;
  always #12.5 clk_i = ~clk_i;
  rcch_top #(.MS_CYCLES(4)) DUT (.*);
  rcch_host u_host (.clk_i(clk_i), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));
  task automatic final_report();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // bounded wait on a sampled flag
  task automatic await(ref logic f, input int lim);
    int k;
    k = 0;
    do begin @(posedge clk_i); k++; end while (f !== 1'b1 && k < lim);
    if (f !== 1'b1)
    begin
      n_fail++;
      final_report();
    end
  endtask
  // one line out, then wait for n answer bytes
  task automatic line(input string s, input int n, input logic [95:0] e);
    int k;
    int s0;
    logic done;
    s0 = u_host.n_rx;
    u_host.send(s);
    for (k = 0; k < 9000 && u_host.n_rx < s0 + n; k++) @(posedge clk_i);
    done = k < 9000;
    await(done, 1);
    `CHK("answer", e, u_host.got & ((96'h1 << 8 * n) - 1))
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
      {2'b11, we, a, 4'hF, d};
    await(wb_ack_o, 50);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic rq(input logic [7:0] id, input logic [15:0] a,
    input logic [15:0] c, input logic hp);
    @(posedge clk_i);
    rem_req_i <= '{1'b1, id, 64'h1, a, 1'b0, c, hp, 32'h5};
    await(rem_ready_o, 50);
    rem_req_i.valid <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rf(input logic u, input logic e);
    @(posedge clk_i);
    rf_rsp_i <= '{1'b1, u, 8'h3, 16'h0, 8'h0, 1'b0, 32'h0};
    @(posedge clk_i);
    rf_rsp_i.valid <= 1'b0;
    @(posedge clk_i);
    `CHK("host frame", e, host_rsp_o.valid)
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    line("+++", 3, 96'h4F_4B0D);
    line("ATDL\r", 2, 96'h300D);
    line("ATBD8\r", 6, 96'h4552_524F_520D);
    line("ATDL1A0D,WR,CN\r", 9, {3{24'h4F_4B0D}});
    `CHK("dest", 32'h0000_1A0D, dest_low_o)
    `CHK("cmd mode", 1'b0, cmd_mode_o)
    $display("text tests done");
    rq(8'h01, 16'hFFFE, rcch_pkg::CODE_RATE, 1'b1);
    `CHK("rsp", 10'h200, {rem_rsp_o.valid, rem_rsp_o.use16,
      rem_rsp_o.status})
    `CHK("rate held", 3'h3, serial_rate_o)
    rq(8'h02, 16'h1234, rcch_pkg::CODE_RATE, 1'b0);
    `CHK("query", 34'h3_0000_0005, {rem_rsp_o.use16, rem_rsp_o.has_value,
      rem_rsp_o.value})
    rq(8'h00, 16'hFFFE, rcch_pkg::CODE_APPLY, 1'b0);
    `CHK("no rsp", 1'b0, rem_rsp_o.valid)
    `CHK("rate applied", 3'h5, serial_rate_o)
    rf(1'b0, 1'b1);
    rf(1'b1, 1'b0);
    rq(8'h03, 16'hFFFE, rcch_pkg::CODE_SWRESET, 1'b0);
    repeat (500) @(posedge clk_i);
    `CHK("soft reset", {3'h3, 32'h0000_1A0D},
      {serial_rate_o, dest_low_o})
    $display("remote tests done");
    wb(1'b0, 4'h2, 32'h0);
    `CHK("unmapped", 32'h0000_0000, q)
    wb(1'b1, 4'hC, 32'h0000_0002);
    wb(1'b0, 4'h4, 32'h0);
    `CHK("restored rate", 32'h0000_0003, q)
    wb(1'b0, 4'h8, 32'h0);
    `CHK("restored dest", 32'h0000_0000, q)
    $display("register tests done");
    final_report();
  end
endmodule
